// ---- core/fpl_pkg.sv ----
// Constants and types shared by the front panel indicator controller
//
// Operation
// - A factory reset is requested only after the button is held down for five seconds without a break.
// - The self test lights every indicator steadily in its own colour for one half second; an indicator already steady white for over 300 s stays dark.
// - A factory reset gives the half second flash unless a self test starts within two seconds of it.
// - Power blinks red twice a second on self test failure, critical update failure or recovery mode.
// - Power is steady red on a critical status, otherwise steady white while powered.
// - Line is steady white when the line is in sync or the link port reaches an optical network terminal.
// - In recovery mode line, internet, wireless and telephony blink white twice a second.
// - Internet is steady white only for a session on the user's own credentials, else off.
// - Telephony is steady white when telephony reports ready.
// - Service blinks yellow twice a second while a remote configuration runs, and goes off after.
// - Self test and factory reset light service steady yellow for one half second.
// - No single pattern is shown on an indicator for longer than 300 seconds.
// - After that limit a newly requested status replaces the old pattern.
package fpl_pkg;

	// Clock and time base
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned MS_CYC        = CLK_HZ / MS_PER_S;
	// Timing figures in their own units
	localparam int unsigned HOLD_S        = 5;
	localparam int unsigned HOLD_MS       = HOLD_S * MS_PER_S;
	localparam int unsigned FLASH_MS      = 500;
	localparam int unsigned ST_WIN_S      = 2;
	localparam int unsigned ST_WIN_MS     = ST_WIN_S * MS_PER_S;
	localparam int unsigned DISP_MAX_S    = 300;
	localparam int unsigned DISP_MAX_MS   = DISP_MAX_S * MS_PER_S;
	localparam int unsigned BLINK_HZ      = 2;
	localparam int unsigned BLINK_HALF_MS = MS_PER_S / (2 * BLINK_HZ);
	// Width of all millisecond counters
	localparam int unsigned CW            = 20;

	// Indicator positions
	localparam int unsigned LED_NUM  = 6;
	localparam int unsigned LED_PWR  = 0;
	localparam int unsigned LED_LINE = 1;
	localparam int unsigned LED_INET = 2;
	localparam int unsigned LED_WLAN = 3;
	localparam int unsigned LED_TEL  = 4;
	localparam int unsigned LED_SVC  = 5;

	typedef enum logic [1:0] {FPL_OFF, FPL_STEADY, FPL_BLINK} fpl_mode_t;
	typedef enum logic [1:0] {FPL_WHITE, FPL_RED, FPL_YELLOW} fpl_color_t;

	typedef struct packed {
		fpl_mode_t  mode;
		fpl_color_t color;
	} fpl_pat_t;

	typedef struct packed {
		logic       lit;
		fpl_color_t color;
	} fpl_led_t;

	// Status from the rest of the router, all on clk_i
	typedef struct packed {
		logic self_test_start;
		logic self_test_fail;
		logic update_fail;
		logic recovery;
		logic critical;
		logic line_sync;
		logic optical_network_terminal;
		logic ppp_user_cred;
		logic wlan_on;
		logic tel_ready;
		logic acs_cfg_busy;
		logic home_gateway_trigger;
	} fpl_status_t;

	// Patterns and reset values
	localparam fpl_pat_t PAT_OFF   = '{mode: FPL_OFF, color: FPL_WHITE};
	localparam fpl_pat_t PAT_W_ON  = '{mode: FPL_STEADY, color: FPL_WHITE};
	localparam fpl_pat_t PAT_W_BLK = '{mode: FPL_BLINK, color: FPL_WHITE};
	localparam fpl_pat_t PAT_R_ON  = '{mode: FPL_STEADY, color: FPL_RED};
	localparam fpl_pat_t PAT_R_BLK = '{mode: FPL_BLINK, color: FPL_RED};
	localparam fpl_pat_t PAT_Y_ON  = '{mode: FPL_STEADY, color: FPL_YELLOW};
	localparam fpl_pat_t PAT_Y_BLK = '{mode: FPL_BLINK, color: FPL_YELLOW};
	localparam fpl_led_t LED_DARK  = '{lit: 1'b0, color: FPL_WHITE};
	localparam logic [1:0] BTN_SYNC_RST = 2'h3;

endpackage

// ---- core/fpl_disp_limit.sv ----
// Per-indicator display time limiter
`timescale 1ns/1ps
`default_nettype none
module fpl_disp_limit #(
	parameter int unsigned LIMIT_MS = fpl_pkg::DISP_MAX_MS
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             tick_i,
	input  wire fpl_pkg::fpl_pat_t pat_i,
	output fpl_pkg::fpl_pat_t     pat_o
);

	if (LIMIT_MS < 1 || LIMIT_MS >= (1 << fpl_pkg::CW)) begin : g_chk
		$error("fpl_disp_limit: LIMIT_MS out of range");
	end

	fpl_pkg::fpl_pat_t            pat_q;
	logic [fpl_pkg::CW-1:0]       cnt_q;
	logic                         expired_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pat_q     <= fpl_pkg::PAT_OFF;
			cnt_q     <= '0;
			expired_q <= 1'b0;
		end else if (pat_i != pat_q) begin
			pat_q     <= pat_i;
			cnt_q     <= '0;
			expired_q <= 1'b0;
		end else if (tick_i && !expired_q) begin
			if (cnt_q == fpl_pkg::CW'(LIMIT_MS - 1)) begin
				expired_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// Expired pattern goes dark until the status changes
	assign pat_o = expired_q ? fpl_pkg::PAT_OFF : pat_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	limit_bound_a: assert property (cnt_q <= fpl_pkg::CW'(LIMIT_MS - 1))
		else $error("display counter passed its limit");
	limit_hit_a: assert property (tick_i && !expired_q && pat_i == pat_q
		&& cnt_q == fpl_pkg::CW'(LIMIT_MS - 1) |=> pat_o == fpl_pkg::PAT_OFF)
		else $error("pattern not stopped at the display limit");
	new_status_a: assert property (pat_i != pat_q |=> pat_o == $past(pat_i))
		else $error("new status did not replace the old pattern");

endmodule // fpl_disp_limit
`default_nettype wire

// ---- core/fpl_led_ctrl.sv ----
// Front panel indicator controller with long-press reset detection
`timescale 1ns/1ps
`default_nettype none
module fpl_led_ctrl #(
	parameter int unsigned MS_CYC        = fpl_pkg::MS_CYC,
	parameter int unsigned HOLD_MS       = fpl_pkg::HOLD_MS,
	parameter int unsigned FLASH_MS      = fpl_pkg::FLASH_MS,
	parameter int unsigned ST_WIN_MS     = fpl_pkg::ST_WIN_MS,
	parameter int unsigned DISP_MAX_MS   = fpl_pkg::DISP_MAX_MS,
	parameter int unsigned BLINK_HALF_MS = fpl_pkg::BLINK_HALF_MS
) (
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_b_i,
	input  wire logic                                 reset_btn_b_i,
	input  wire fpl_pkg::fpl_status_t                 status_i,
	output fpl_pkg::fpl_led_t [fpl_pkg::LED_NUM-1:0]  leds_o,
	output logic                                      factory_reset_o
);

	localparam int unsigned CW = fpl_pkg::CW;
	localparam int unsigned TW = $clog2(MS_CYC + 1);

	// Parameters the counters cannot serve
	if (MS_CYC < 2 || HOLD_MS < 1 || FLASH_MS < 1 || ST_WIN_MS < 1
		|| BLINK_HALF_MS < 1 || HOLD_MS >= (1 << CW)
		|| ST_WIN_MS >= (1 << CW) || FLASH_MS >= (1 << CW)
		|| BLINK_HALF_MS >= (1 << CW)) begin : g_chk
		$error("fpl_led_ctrl: timing parameter out of range");
	end

	typedef enum logic [1:0] {S_IDLE, S_WAIT, S_FLASH} fpl_seq_t;

	logic [TW-1:0]                            tick_cnt_q;
	logic                                     tick_q;
	logic [1:0]                               btn_sync_q;
	logic                                     pressed;
	logic [CW-1:0]                            hold_cnt_q;
	logic                                     hold_done_q;
	logic                                     fr_q;
	logic [CW-1:0]                            blink_cnt_q;
	logic                                     blink_ph_q;
	fpl_seq_t                                 state_q;
	logic [CW-1:0]                            seq_cnt_q;
	logic                                     flash;
	logic                                     st_start;
	logic                                     rec;
	logic [fpl_pkg::LED_NUM-1:0]              on_cond;
	fpl_pkg::fpl_pat_t [fpl_pkg::LED_NUM-1:0] req_pat;
	fpl_pkg::fpl_pat_t [fpl_pkg::LED_NUM-1:0] shown;
	fpl_pkg::fpl_led_t [fpl_pkg::LED_NUM-1:0] leds_q;

	// Millisecond time base; keeps every long count small
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TW'(MS_CYC - 1)) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q     <= 1'b0;
		end
	end

	// Button pin is asynchronous: two flops first
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			btn_sync_q <= fpl_pkg::BTN_SYNC_RST;
		end else begin
			btn_sync_q <= {btn_sync_q[0], reset_btn_b_i};
		end
	end

	assign pressed = !btn_sync_q[1];

	// continuous hold count
	// Any release restarts it; one request per press
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_cnt_q  <= '0;
			hold_done_q <= 1'b0;
			fr_q        <= 1'b0;
		end else if (!pressed) begin
			hold_cnt_q  <= '0;
			hold_done_q <= 1'b0;
			fr_q        <= 1'b0;
		end else if (tick_q && !hold_done_q) begin
			if (hold_cnt_q == CW'(HOLD_MS - 1)) begin
				hold_done_q <= 1'b1;
				fr_q        <= 1'b1;
			end else begin
				hold_cnt_q <= hold_cnt_q + 1'b1;
				fr_q       <= 1'b0;
			end
		end else begin
			fr_q <= 1'b0;
		end
	end

	assign factory_reset_o = fr_q;

	// free-running 250 ms half period
	// Shared phase keeps all blinking indicators in step
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			blink_cnt_q <= '0;
			blink_ph_q  <= 1'b0;
		end else if (tick_q) begin
			if (blink_cnt_q == CW'(BLINK_HALF_MS - 1)) begin
				blink_cnt_q <= '0;
				blink_ph_q  <= !blink_ph_q;
			end else begin
				blink_cnt_q <= blink_cnt_q + 1'b1;
			end
		end
	end

	assign st_start = status_i.self_test_start;

	// reset waits for a self test before its flash
	// Reset flash comes after the whole window, so it is late by 2 s
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q   <= S_IDLE;
			seq_cnt_q <= '0;
		end else if (st_start) begin
			state_q   <= S_FLASH;
			seq_cnt_q <= '0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (fr_q) begin
						state_q   <= S_WAIT;
						seq_cnt_q <= '0;
					end
				end
				S_WAIT: begin
					if (tick_q) begin
						if (seq_cnt_q == CW'(ST_WIN_MS - 1)) begin
							state_q   <= S_FLASH;
							seq_cnt_q <= '0;
						end else begin
							seq_cnt_q <= seq_cnt_q + 1'b1;
						end
					end
				end
				S_FLASH: begin
					if (tick_q) begin
						if (seq_cnt_q == CW'(FLASH_MS - 1)) begin
							state_q   <= S_IDLE;
							seq_cnt_q <= '0;
						end else begin
							seq_cnt_q <= seq_cnt_q + 1'b1;
						end
					end
				end
				default: begin
					state_q   <= S_IDLE;
					seq_cnt_q <= '0;
				end
			endcase
		end
	end

	assign flash = (state_q == S_FLASH);
	assign rec   = status_i.recovery;

	// Steady conditions of the four white status indicators
	always_comb begin
		on_cond = '0;
		on_cond[fpl_pkg::LED_LINE] = status_i.line_sync || status_i.optical_network_terminal;
		on_cond[fpl_pkg::LED_INET] = status_i.ppp_user_cred;
		on_cond[fpl_pkg::LED_WLAN] = status_i.wlan_on;
		on_cond[fpl_pkg::LED_TEL]  = status_i.tel_ready;
	end

	// Requested pattern per indicator, flash first
	always_comb begin
		req_pat = {fpl_pkg::LED_NUM{fpl_pkg::PAT_OFF}};
		if (flash) begin
			req_pat[fpl_pkg::LED_PWR] = fpl_pkg::PAT_W_ON;
		end else if (status_i.self_test_fail || status_i.update_fail || rec) begin
			req_pat[fpl_pkg::LED_PWR] = fpl_pkg::PAT_R_BLK;
		end else if (status_i.critical) begin
			req_pat[fpl_pkg::LED_PWR] = fpl_pkg::PAT_R_ON;
		end else begin
			req_pat[fpl_pkg::LED_PWR] = fpl_pkg::PAT_W_ON;
		end
		for (int i = fpl_pkg::LED_LINE; i <= fpl_pkg::LED_TEL; i++) begin
			if (flash) begin
				req_pat[i] = fpl_pkg::PAT_W_ON;
			end else if (rec) begin
				req_pat[i] = fpl_pkg::PAT_W_BLK;
			end else if (on_cond[i]) begin
				req_pat[i] = fpl_pkg::PAT_W_ON;
			end
		end
		if (flash) begin
			req_pat[fpl_pkg::LED_SVC] = fpl_pkg::PAT_Y_ON;
		end else if (status_i.acs_cfg_busy || status_i.home_gateway_trigger) begin
			req_pat[fpl_pkg::LED_SVC] = fpl_pkg::PAT_Y_BLK;
		end
	end

	for (genvar g = 0; g < fpl_pkg::LED_NUM; g++) begin : g_lim
		fpl_disp_limit #(
			.LIMIT_MS (DISP_MAX_MS)
		) u_lim (
			.clk_i   (clk_i),
			.rst_b_i (rst_b_i),
			.tick_i  (tick_q),
			.pat_i   (req_pat[g]),
			.pat_o   (shown[g])
		);
	end

	// blink phase gates the drive
	// Registered so the pins never glitch
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			leds_q <= {fpl_pkg::LED_NUM{fpl_pkg::LED_DARK}};
		end else begin
			for (int i = 0; i < fpl_pkg::LED_NUM; i++) begin
				leds_q[i].lit   <= (shown[i].mode == fpl_pkg::FPL_STEADY)
					|| (shown[i].mode == fpl_pkg::FPL_BLINK && blink_ph_q);
				leds_q[i].color <= shown[i].color;
			end
		end
	end

	assign leds_o = leds_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	long_press_a: assert property (factory_reset_o |-> $past(pressed)
		&& $past(hold_cnt_q) == CW'(HOLD_MS - 1))
		else $error("factory reset without a full hold");
	press_release_a: assert property (!pressed |=> !factory_reset_o && hold_cnt_q == '0)
		else $error("hold count survived a release");
	flash_len_a: assert property (flash |-> seq_cnt_q < CW'(FLASH_MS))
		else $error("flash longer than its interval");
	skip_flash_a: assert property (state_q == S_WAIT && st_start
		|=> flash && seq_cnt_q == '0)
		else $error("self test did not take over the reset window");
	win_end_a: assert property (state_q == S_WAIT && !st_start && tick_q
		&& seq_cnt_q == CW'(ST_WIN_MS - 1) |=> flash)
		else $error("reset flash missing after the window");
	flash_colour_a: assert property (flash |-> req_pat[fpl_pkg::LED_SVC] == fpl_pkg::PAT_Y_ON
		&& req_pat[fpl_pkg::LED_PWR] == fpl_pkg::PAT_W_ON)
		else $error("flash colours wrong");
	pwr_blink_a: assert property (!flash && (status_i.self_test_fail || rec)
		|-> req_pat[fpl_pkg::LED_PWR] == fpl_pkg::PAT_R_BLK)
		else $error("power not blinking red");
	pwr_crit_a: assert property (!flash && !rec && !status_i.self_test_fail
		&& !status_i.update_fail && status_i.critical
		|-> req_pat[fpl_pkg::LED_PWR] == fpl_pkg::PAT_R_ON)
		else $error("power not steady red on critical");
	line_on_a: assert property (!flash && !rec && status_i.optical_network_terminal
		|-> req_pat[fpl_pkg::LED_LINE] == fpl_pkg::PAT_W_ON)
		else $error("line indicator not lit");
	recov_blink_a: assert property (!flash && rec
		|-> req_pat[fpl_pkg::LED_TEL] == fpl_pkg::PAT_W_BLK
		&& req_pat[fpl_pkg::LED_INET] == fpl_pkg::PAT_W_BLK)
		else $error("recovery blink missing");
	inet_off_a: assert property (!flash && !rec && !status_i.ppp_user_cred
		|-> req_pat[fpl_pkg::LED_INET] == fpl_pkg::PAT_OFF)
		else $error("internet lit without user credentials");
	tel_on_a: assert property (!flash && !rec && status_i.tel_ready
		|-> req_pat[fpl_pkg::LED_TEL] == fpl_pkg::PAT_W_ON)
		else $error("telephony not lit when ready");
	svc_off_a: assert property (!flash && !status_i.acs_cfg_busy
		&& !status_i.home_gateway_trigger |-> req_pat[fpl_pkg::LED_SVC] == fpl_pkg::PAT_OFF)
		else $error("service lit with no remote action");
	blink_half_a: assert property (tick_q && blink_cnt_q == CW'(BLINK_HALF_MS - 1)
		|=> blink_ph_q != $past(blink_ph_q) && blink_cnt_q == '0)
		else $error("blink phase not toggled at 250 ms");
	// blink follows phase at the pin
	blink_pin_a: assert property (shown[fpl_pkg::LED_SVC].mode == fpl_pkg::FPL_BLINK
		|=> leds_o[fpl_pkg::LED_SVC].lit == $past(blink_ph_q))
		else $error("blinking output does not follow the phase");
	wlan_off_a: assert property (!flash && !rec && !status_i.wlan_on
		|-> req_pat[fpl_pkg::LED_WLAN] == fpl_pkg::PAT_OFF)
		else $error("wireless lit with radio off");

endmodule // fpl_led_ctrl
`default_nettype wire

// ---- dv/fpl_src_model.sv ----
// Model of the router status sources and the recessed reset button
`timescale 1ns/1ps
`default_nettype none
module fpl_src_model (
	input  wire logic            clk_i,
	output fpl_pkg::fpl_status_t status_o,
	output logic                 btn_b_o
);
	// Quiet sources; released button sits at its pull-up
	initial begin
		status_o = '0;
		btn_b_o  = 1'b1;
	end
	// Status levels change just after an edge
	task automatic set(input fpl_pkg::fpl_status_t st);
		@(posedge clk_i);
		status_o <= st;
	endtask
	// One cycle of start request is enough for the self test
	task automatic pulse_start();
		@(posedge clk_i);
		status_o.self_test_start <= 1'b1;
		@(posedge clk_i);
		status_o.self_test_start <= 1'b0;
	endtask
	// Press held without a break, then back to the pull-up level
	task automatic press(input int n);
		@(posedge clk_i);
		btn_b_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		btn_b_o <= 1'b1;
	endtask
endmodule // fpl_src_model
`default_nettype wire

// ---- dv/fpl_tb.sv ----
// Self-checking bench for the front panel indicator controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// Short counts keep the run small; expectations follow from them
	localparam int unsigned MSC   = 4;
	localparam int unsigned HOLD  = 5;
	localparam int unsigned FLSH  = 4;
	localparam int unsigned WIN   = 6;
	localparam int unsigned DLIM  = 40;
	localparam int unsigned BHALF = 2;
	localparam fpl_pkg::fpl_pat_t p_off = fpl_pkg::PAT_OFF;
	localparam fpl_pkg::fpl_pat_t p_won = fpl_pkg::PAT_W_ON;
	localparam fpl_pkg::fpl_pat_t p_wbk = fpl_pkg::PAT_W_BLK;
	localparam fpl_pkg::fpl_pat_t p_ron = fpl_pkg::PAT_R_ON;
	localparam fpl_pkg::fpl_pat_t p_rbk = fpl_pkg::PAT_R_BLK;
	localparam fpl_pkg::fpl_pat_t p_ybk = fpl_pkg::PAT_Y_BLK;
	logic                                     clk_i;
	logic                                     rst_b_i;
	logic                                     btn_b;
	fpl_pkg::fpl_status_t                     status;
	fpl_pkg::fpl_led_t [fpl_pkg::LED_NUM-1:0] leds_o;
	logic                                     factory_reset_o;
	int                                       num_errors;
	int                                       cmp_count;

	// 50 MHz clock
	initial clk_i = 1'b0;
	always #10 clk_i = ~clk_i;

	fpl_src_model SRC (.clk_i(clk_i), .status_o(status), .btn_b_o(btn_b));
	fpl_led_ctrl #(.MS_CYC(MSC), .HOLD_MS(HOLD), .FLASH_MS(FLSH), .ST_WIN_MS(WIN), .DISP_MAX_MS(DLIM),
		.BLINK_HALF_MS(BHALF)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .reset_btn_b_i(btn_b),
		.status_i(status), .leds_o(leds_o), .factory_reset_o(factory_reset_o));

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input int lo, input int hi, input int got);
		cmp_count++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	// Leaving through a critical status makes every new status other than critical a real change
	task automatic apply(input fpl_pkg::fpl_status_t st);
		fpl_pkg::fpl_status_t c;
		c = '0;
		c.critical = 1'b1;
		SRC.set(c);
		repeat (8) @(posedge clk_i);
		SRC.set(st);
		repeat (8) @(posedge clk_i);
	endtask
	// Two blink periods: steady gives 32 lit cycles, blink exactly 16
	task automatic watch(input string nm, input fpl_pkg::fpl_pat_t e [6]);
		int k [6];
		int bad [6];
		int x;
		k = '{default: 0};
		bad = '{default: 0};
		repeat (32) begin
			@(negedge clk_i);
			for (int i = 0; i < 6; i++) begin
				if (leds_o[i].lit === 1'b1) begin
					k[i]++;
					if (leds_o[i].color !== e[i].color) bad[i]++;
				end
			end
		end
		for (int i = 0; i < 6; i++) begin
			x = (e[i].mode == fpl_pkg::FPL_OFF) ? 0 : (e[i].mode == fpl_pkg::FPL_STEADY) ? 32 : 16;
			chk($sformatf("%s lit %0d", nm, i), x, x, k[i]);
			chk($sformatf("%s colour %0d", nm, i), 0, 0, bad[i]);
		end
		$display("Test %s done", nm);
	endtask
	task automatic cnt_lit(input int idx, input int n, input fpl_pkg::fpl_color_t c, output int k);
		k = 0;
		repeat (n) begin
			@(negedge clk_i);
			if (leds_o[idx].lit === 1'b1 && leds_o[idx].color === c) k++;
		end
	endtask
	task automatic cnt_pulse(input int n, output int k);
		k = 0;
		repeat (n) begin
			@(negedge clk_i);
			if (factory_reset_o === 1'b1) k++;
		end
	endtask
	// Bounded wait for the reset request; a miss ends the run
	task automatic wait_pulse();
		int n;
		n = 0;
		while (factory_reset_o !== 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		chk("hold time", 16, 39, n);
		if (n >= 40) end_of_test();
	endtask

	task automatic t_reset();
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		chk("reset outputs", 1, 1, int'(leds_o === '0 && factory_reset_o === 1'b0));
		@(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk("power on", 1, 1, int'(leds_o[0].lit === 1'b1 && leds_o[0].color === fpl_pkg::FPL_WHITE));
		$display("Test reset done");
	endtask
	task automatic t_fault();
		fpl_pkg::fpl_status_t st;
		st = '0;
		st.self_test_fail = 1'b1;
		apply(st);
		watch("self test fail", '{p_rbk, p_off, p_off, p_off, p_off, p_off});
		st = '0;
		st.update_fail = 1'b1;
		apply(st);
		watch("update fail", '{p_rbk, p_off, p_off, p_off, p_off, p_off});
		st = '0;
		st.critical = 1'b1;
		apply(st);
		watch("critical", '{p_ron, p_off, p_off, p_off, p_off, p_off});
	endtask
	task automatic t_steady();
		fpl_pkg::fpl_status_t st;
		st = '0;
		st.line_sync = 1'b1;
		st.ppp_user_cred = 1'b1;
		st.wlan_on = 1'b1;
		st.tel_ready = 1'b1;
		apply(st);
		watch("all ready", '{p_won, p_won, p_won, p_won, p_won, p_off});
		st = '0;
		st.optical_network_terminal = 1'b1;
		apply(st);
		watch("terminal only", '{p_won, p_won, p_off, p_off, p_off, p_off});
	endtask
	task automatic t_recov();
		fpl_pkg::fpl_status_t st;
		st = '0;
		st.recovery = 1'b1;
		st.line_sync = 1'b1;
		st.acs_cfg_busy = 1'b1;
		apply(st);
		watch("recovery", '{p_rbk, p_wbk, p_wbk, p_wbk, p_wbk, p_ybk});
	endtask
	task automatic t_svc();
		fpl_pkg::fpl_status_t st;
		st = '0;
		st.home_gateway_trigger = 1'b1;
		apply(st);
		watch("gateway config", '{p_won, p_off, p_off, p_off, p_off, p_ybk});
		st = '0;
		apply(st);
		watch("config over", '{p_won, p_off, p_off, p_off, p_off, p_off});
	endtask
	// Power starts red so the white flash is visible on it too
	task automatic t_flash();
		fpl_pkg::fpl_status_t st;
		int k0, k1, k5;
		st = '0;
		st.critical = 1'b1;
		apply(st);
		fork
			SRC.pulse_start();
			cnt_lit(0, 40, fpl_pkg::FPL_WHITE, k0);
			cnt_lit(1, 40, fpl_pkg::FPL_WHITE, k1);
			cnt_lit(5, 40, fpl_pkg::FPL_YELLOW, k5);
		join
		chk("flash power", 13, 16, k0);
		chk("flash line", 13, 16, k1);
		chk("flash service", 13, 16, k5);
		$display("Test flash done");
	endtask
	task automatic t_factory();
		fpl_pkg::fpl_status_t st;
		int k, p;
		st = '0;
		apply(st);
		fork
			SRC.press(12);
			cnt_pulse(30, p);
		join
		chk("short press", 0, 0, p);
		fork
			SRC.press(40);
			begin
				wait_pulse();
				fork
					cnt_lit(1, 16, fpl_pkg::FPL_WHITE, k);
					cnt_pulse(16, p);
				join
			end
		join
		chk("one pulse", 0, 0, p);
		chk("flash delayed", 0, 0, k);
		cnt_lit(5, 48, fpl_pkg::FPL_YELLOW, k);
		chk("reset flash", 13, 16, k);
		fork
			SRC.press(40);
			begin
				wait_pulse();
				fork
					begin
						repeat (6) @(posedge clk_i);
						SRC.pulse_start();
					end
					cnt_lit(1, 80, fpl_pkg::FPL_WHITE, k);
				join
			end
		join
		chk("single flash", 13, 16, k);
		$display("Test factory reset done");
	endtask
	// Unchanged steady power goes dark after the limit, a new status shows at once
	task automatic t_limit();
		fpl_pkg::fpl_status_t st;
		int k;
		st = '0;
		apply(st);
		cnt_lit(0, 130, fpl_pkg::FPL_WHITE, k);
		chk("before limit", 130, 130, k);
		repeat (30) @(posedge clk_i);
		cnt_lit(0, 10, fpl_pkg::FPL_WHITE, k);
		chk("after limit", 0, 0, k);
		st.critical = 1'b1;
		SRC.set(st);
		repeat (4) @(posedge clk_i);
		cnt_lit(0, 8, fpl_pkg::FPL_RED, k);
		chk("new status", 8, 8, k);
		$display("Test display limit done");
	endtask

	// Main sequence
	initial begin
		num_errors = 0;
		cmp_count = 0;
		rst_b_i = 1'b0;
		t_reset();
		t_fault();
		t_steady();
		t_recov();
		t_svc();
		t_flash();
		t_factory();
		t_limit();
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
